// ---- inc/bel_defs.svh ----
// Register offsets, field positions, reset values and field constants of the error-locator root search block.
// Assumes a byte-addressed APB slave window of 256 bytes, one aligned 32-bit word per register.
`ifndef BEL_DEFS_SVH
`define BEL_DEFS_SVH
`define BEL_OFF_CONFIG      8'h00
`define BEL_OFF_PRIMITIVE   8'h04
`define BEL_OFF_START       8'h08
`define BEL_OFF_STOP        8'h0c
`define BEL_OFF_STATUS      8'h10
`define BEL_OFF_IRQ_ENABLE  8'h14
`define BEL_OFF_IRQ_DISABLE 8'h18
`define BEL_OFF_IRQ_MASK    8'h1c
`define BEL_OFF_IRQ_STATUS  8'h20
`define BEL_OFF_COEF_FIRST  8'h28
`define BEL_OFF_COEF_LAST   8'h88
`define BEL_OFF_POS_FIRST   8'h8c
`define BEL_OFF_POS_LAST    8'he4
`define BEL_NUM_COEF        25
`define BEL_NUM_POS         24
`define BEL_FLD_W           14
`define BEL_CFG_SECTOR_BIT  0
`define BEL_CFG_ERRNUM_LSB  16
`define BEL_CFG_ERRNUM_W    5
`define BEL_ERRCNT_LSB      8
`define BEL_ERRCNT_W        5
`define BEL_DONE_BIT        0
`define BEL_BUSY_BIT        0
`define BEL_POLY_GF13       15'h201b
`define BEL_POLY_GF14       15'h4443
`define BEL_MASK_GF13       14'h1fff
`define BEL_MASK_GF14       14'h3fff
`define BEL_SECTOR_BITS_512 14'h1000
`define BEL_SECTOR_BITS_1K  14'h2000
`define BEL_RESET_WORD      32'h0000_0000
`endif

// ---- inc/bel_pkg.sv ----
// Types of the error-locator root search block: engine state and the full packed register state.
// Assumes bel_defs.svh is on the include path.
`include "bel_defs.svh"
package bel_pkg;
  typedef enum logic [0:0] {
    BEL_IDLE   = 1'b0,
    BEL_SEARCH = 1'b1
  } bel_state_t;

  typedef logic [`BEL_FLD_W-1:0] bel_elem_t;

  typedef struct packed {
    bel_state_t                         state;
    logic                               sector_1k;
    logic [`BEL_CFG_ERRNUM_W-1:0]       errnum;
    bel_elem_t                          elem_count;
    bel_elem_t                          step;
    logic [`BEL_NUM_COEF-1:0][`BEL_FLD_W-1:0] coef;
    logic [`BEL_NUM_COEF-1:0][`BEL_FLD_W-1:0] term;
    logic [`BEL_NUM_POS-1:0][`BEL_FLD_W-1:0]  pos;
    logic [`BEL_ERRCNT_W-1:0]           error_counter;
    logic                               done;
    logic                               mask;
    logic                               irq;
    logic                               pready;
    logic                               pslverr;
    logic [31:0]                        prdata;
  } bel_state_reg_t;
endpackage

// ---- rtl/bel_error_locator.sv ----
// Error-locator root search engine over GF(2^13) or GF(2^14), with an APB register slave and one interrupt.
// Assumes APB inputs come from logic on i_core_clk; one field element is tested per clock cycle.
`timescale 1ns/1ps
`include "bel_defs.svh"
module bel_error_locator
  import bel_pkg::*;
#(
  parameter logic [14:0] POLY_GF13 = `BEL_POLY_GF13,
  parameter logic [14:0] POLY_GF14 = `BEL_POLY_GF14
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_irq
);

  bel_state_reg_t q_reg;
  bel_state_reg_t q_next;

  // Multiply by the inverse of alpha; the primitive polynomial has bit 0 set, so the division is exact.
  function automatic bel_elem_t mul_inv_alpha(input bel_elem_t x, input logic [14:0] poly);
    logic [14:0] t;
    t = {1'b0, x} ^ (x[0] ? poly : 15'h0000);
    return t[14:1];
  endfunction

  // Multiply by alpha to the power minus j, one shift per degree step.
  function automatic bel_elem_t mul_inv_pow(input bel_elem_t x, input int j, input logic [14:0] poly);
    bel_elem_t y;
    y = x;
    for (int k = 0; k < `BEL_NUM_COEF - 1; k++) begin
      if (k < j) begin
        y = mul_inv_alpha(y, poly);
      end
    end
    return y;
  endfunction

  logic [14:0] poly;
  bel_elem_t   fmask;
  bel_elem_t   sector_bits;
  bel_elem_t   eval_sum;
  bel_elem_t   raw_pos;
  bel_elem_t   rep_pos;
  bel_elem_t   term_step [`BEL_NUM_COEF];
  logic        access;
  logic        wr_take;
  logic [5:0]  widx;
  logic [5:0]  coef_idx;
  logic [5:0]  pos_idx;
  logic        is_coef;
  logic        is_pos;
  logic        mapped;
  logic [31:0] rd_word;
  logic        done_set;

  // Field selection follows the sector size bit.
  assign poly        = q_reg.sector_1k ? POLY_GF14 : POLY_GF13;
  assign fmask       = q_reg.sector_1k ? `BEL_MASK_GF14 : `BEL_MASK_GF13;
  assign sector_bits = q_reg.sector_1k ? `BEL_SECTOR_BITS_1K : `BEL_SECTOR_BITS_512;

  // Each degree term advances by its own power of alpha inverse every search cycle.
  genvar g;
  generate
    for (g = 0; g < `BEL_NUM_COEF; g++) begin : g_term
      assign term_step[g] = mul_inv_pow(q_reg.term[g], g, poly);
    end
  endgenerate

  always_comb begin
    eval_sum = '0;
    for (int j = 0; j < `BEL_NUM_COEF; j++) begin
      eval_sum = eval_sum ^ q_reg.term[j];
    end
  end

  // Step p tests alpha^-p; the codeword's first main bit is the highest degree, reported as 0.
  // Reported values past the main area skip one code so the spare area starts one above the sector size.
  assign raw_pos = q_reg.elem_count - 14'h0001 - q_reg.step;
  assign rep_pos = (raw_pos >= sector_bits) ? raw_pos + 14'h0001 : raw_pos;

  assign access   = i_psel & i_penable;
  assign wr_take  = access & q_reg.pready & i_pwrite;
  assign widx     = i_paddr[7:2];
  assign is_coef  = (i_paddr >= `BEL_OFF_COEF_FIRST) && (i_paddr <= `BEL_OFF_COEF_LAST);
  assign is_pos   = (i_paddr >= `BEL_OFF_POS_FIRST) && (i_paddr <= `BEL_OFF_POS_LAST);
  assign coef_idx = widx - 6'(`BEL_OFF_COEF_FIRST >> 2);
  assign pos_idx  = widx - 6'(`BEL_OFF_POS_FIRST >> 2);
  assign mapped   = (i_paddr[1:0] == 2'b00) && (is_coef || is_pos || (i_paddr <= `BEL_OFF_IRQ_STATUS));

  always_comb begin
    rd_word = `BEL_RESET_WORD;
    if (is_coef) begin
      rd_word[`BEL_FLD_W-1:0] = q_reg.coef[coef_idx[4:0]];
    end else if (is_pos) begin
      rd_word[`BEL_FLD_W-1:0] = q_reg.pos[pos_idx[4:0]];
    end else begin
      unique case (i_paddr)
        `BEL_OFF_CONFIG: begin
          rd_word[`BEL_CFG_SECTOR_BIT] = q_reg.sector_1k;
          rd_word[`BEL_CFG_ERRNUM_LSB +: `BEL_CFG_ERRNUM_W] = q_reg.errnum;
        end
        `BEL_OFF_PRIMITIVE: begin
          rd_word[14:0] = poly;
        end
        `BEL_OFF_START: begin
          rd_word[`BEL_FLD_W-1:0] = q_reg.elem_count;
        end
        `BEL_OFF_STATUS: begin
          rd_word[`BEL_BUSY_BIT] = (q_reg.state == BEL_SEARCH);
        end
        `BEL_OFF_IRQ_MASK: begin
          rd_word[`BEL_DONE_BIT] = q_reg.mask;
        end
        `BEL_OFF_IRQ_STATUS: begin
          rd_word[`BEL_DONE_BIT] = q_reg.done;
          rd_word[`BEL_ERRCNT_LSB +: `BEL_ERRCNT_W] = q_reg.error_counter;
        end
        default: begin
          rd_word = `BEL_RESET_WORD;
        end
      endcase
    end
  end

  always_comb begin
    q_next   = q_reg;
    done_set = 1'b0;

    // One wait state: the answer is registered, so read data and error are stable with pready.
    q_next.pready  = access & ~q_reg.pready;
    q_next.pslverr = 1'b0;
    if (access & ~q_reg.pready) begin
      q_next.prdata  = i_pwrite ? `BEL_RESET_WORD : rd_word;
      q_next.pslverr = ~mapped;
    end

    // Search engine: one candidate element per cycle.
    unique case (q_reg.state)
      BEL_IDLE: begin
        q_next.state = BEL_IDLE;
      end
      BEL_SEARCH: begin
        if (eval_sum == '0) begin
          if (q_reg.error_counter < 5'(`BEL_NUM_POS)) begin
            q_next.pos[q_reg.error_counter] = rep_pos;
            q_next.error_counter = q_reg.error_counter + 5'h01;
          end
        end
        for (int j = 0; j < `BEL_NUM_COEF; j++) begin
          q_next.term[j] = term_step[j];
        end
        q_next.step = q_reg.step + 14'h0001;
        if (q_reg.step >= q_reg.elem_count - 14'h0001) begin
          q_next.state = BEL_IDLE;
          done_set     = 1'b1;
        end
      end
    endcase

    if (wr_take) begin
      if (is_coef && i_paddr[1:0] == 2'b00) begin
        q_next.coef[coef_idx[4:0]] = i_pwdata[`BEL_FLD_W-1:0];
      end
      unique case (i_paddr)
        `BEL_OFF_CONFIG: begin
          q_next.sector_1k = i_pwdata[`BEL_CFG_SECTOR_BIT];
          q_next.errnum    = i_pwdata[`BEL_CFG_ERRNUM_LSB +: `BEL_CFG_ERRNUM_W];
        end
        `BEL_OFF_START: begin
          // A new search restarts cleanly; the count comes from software as is.
          q_next.elem_count = i_pwdata[`BEL_FLD_W-1:0];
          q_next.step       = '0;
          q_next.error_counter    = '0;
          q_next.pos        = '0;
          done_set          = 1'b0;
          for (int j = 0; j < `BEL_NUM_COEF; j++) begin
            q_next.term[j] = q_reg.coef[j] & fmask;
          end
          if (i_pwdata[`BEL_FLD_W-1:0] == '0) begin
            q_next.state = BEL_IDLE;
            done_set     = 1'b1;
          end else begin
            q_next.state = BEL_SEARCH;
          end
        end
        `BEL_OFF_STOP: begin
          q_next.state = BEL_IDLE;
          done_set     = 1'b0;
        end
        `BEL_OFF_IRQ_ENABLE: begin
          if (i_pwdata[`BEL_DONE_BIT]) begin
            q_next.mask = 1'b1;
          end
        end
        `BEL_OFF_IRQ_DISABLE: begin
          if (i_pwdata[`BEL_DONE_BIT]) begin
            q_next.mask = 1'b0;
          end
        end
        `BEL_OFF_IRQ_STATUS: begin
          if (i_pwdata[`BEL_DONE_BIT]) begin
            q_next.done = 1'b0;
          end
        end
        default: begin
          q_next.mask = q_next.mask;
        end
      endcase
    end

    // Completion beats a clear in the same cycle; a stop or start write in that cycle discards the completion.
    if (done_set) begin
      q_next.done = 1'b1;
    end
    q_next.irq = q_next.done & q_next.mask;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      q_reg       <= '0;
      q_reg.state <= BEL_IDLE;
    end else begin
      q_reg <= q_next;
    end
  end

  assign o_prdata  = q_reg.prdata;
  assign o_pready  = q_reg.pready;
  assign o_pslverr = q_reg.pslverr;
  assign o_irq     = q_reg.irq;

endmodule

// ---- tb/bel_checker.sv ----
// Checker of the root search block: bus timing, refusals and interrupt.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`include "bel_defs.svh"
module bel_checker (
  input wire logic        i_core_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_irq
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  property p_wait; i_psel && i_penable && !$past(i_penable) |=> o_pready; endproperty
  a_wait: assert property (p_wait) else $error("ready not after one wait state");
  property p_pulse; o_pready |=> !o_pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_in_access; o_pready |-> $past(i_psel && i_penable); endproperty
  a_in_access: assert property (p_in_access) else $error("ready outside a transfer");
  property p_err_ready; o_pslverr |-> o_pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_hole; o_pready && (i_paddr == 8'h24 || i_paddr == 8'he8) |-> o_pslverr; endproperty
  a_hole: assert property (p_hole) else $error("reserved address accepted");
  property p_wr_zero; o_pready && i_pwrite |-> o_prdata == 32'h0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write returned data");
  property p_prim; o_pready && !i_pwrite && i_paddr == 8'h04
    |-> o_prdata inside {{17'h0, `BEL_POLY_GF13}, {17'h0, `BEL_POLY_GF14}}; endproperty
  a_prim: assert property (p_prim) else $error("bad primitive polynomial");
  property p_mask_off; o_pready && i_pwrite && i_paddr == 8'h18 && i_pwdata[0] |=> !o_irq; endproperty
  a_mask_off: assert property (p_mask_off) else $error("interrupt after disable");
  property p_stop; !o_irq && o_pready && i_pwrite && i_paddr == 8'h0c |=> !o_irq; endproperty
  a_stop: assert property (p_stop) else $error("stop raised interrupt");
endmodule
bind bel_error_locator bel_checker bel_checker_inst (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq));

// ---- tb/testbench.sv ----
// Self-checking bench of the root search block, driven over APB.
// Assumes one clock; polynomial 1+x has its only tested root at the first step.
`timescale 1ns/1ps
`include "bel_defs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  import bel_pkg::*;
  typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} bel_row_t;
  logic        i_core_clk = 1'b0;
  logic        i_sys_rst  = 1'b1;
  logic        i_psel     = 1'b0;
  logic        i_penable  = 1'b0;
  logic        i_pwrite   = 1'b0;
  logic [7:0]  i_paddr    = 8'h00;
  logic [31:0] i_pwdata   = 32'h0;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic        o_irq;
  int          mismatches = 0;
  int          n_checks   = 0;
  logic [31:0] q;
  logic        e;
  int          n;
  bel_row_t rows [13] = '{
    '{8'h00, 1'b0, 32'h0, 32'h0, 1'b0},
    '{8'h1c, 1'b0, 32'h0, 32'h0, 1'b0},
    '{8'h20, 1'b0, 32'h0, 32'h0, 1'b0},
    '{8'h04, 1'b0, 32'h0, 32'h201b, 1'b0},
    '{8'h00, 1'b1, 32'h1, 32'h0, 1'b0},
    '{8'h04, 1'b1, 32'hffff, 32'h0, 1'b0},
    '{8'h04, 1'b0, 32'h0, 32'h4443, 1'b0},
    '{8'h24, 1'b0, 32'h0, 32'h0, 1'b1},
    '{8'he8, 1'b1, 32'h1, 32'h0, 1'b1},
    '{8'h28, 1'b1, 32'h1, 32'h0, 1'b0},
    '{8'h2c, 1'b1, 32'h1, 32'h0, 1'b0},
    '{8'h88, 1'b1, 32'h3fff, 32'h0, 1'b0},
    '{8'h88, 1'b0, 32'h0, 32'h3fff, 1'b0}
  };
  bel_error_locator bel_error_locator_inst (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq));
  always #2.5 i_core_clk = ~i_core_clk;
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_core_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    if (k >= 20) mismatches++;
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0);
    `CHK(q, x)
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge i_core_clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      `CHK(q, rows[i].x)
      `CHK(e, rows[i].e)
    end
    // The top coefficient was only a readback probe; clear it so the locator is exactly 1+x.
    apb(8'h88, 1'b1, 32'h0);
    apb(8'h14, 1'b1, 32'h1);
    rd(8'h1c, 32'h1);
    for (int m = 0; m < 2; m++) begin
      // Largest 512-byte and smallest 1024-byte counts; the root lands in the spare area.
      n = (m == 0) ? 4122 : 8220;
      apb(8'h00, 1'b1, 32'(m));
      if (m == 1) apb(8'h18, 1'b1, 32'h1);
      apb(8'h08, 1'b1, 32'(n));
      repeat (n) @(posedge i_core_clk);
      `CHK(o_irq, 1'b0)
      @(posedge i_core_clk);
      `CHK(o_irq, m == 0)
      rd(8'h10, 32'h0);
      rd(8'h20, 32'h101);
      rd(8'h8c, 32'(n));
      rd(8'h90, 32'h0);
      apb(8'h20, 1'b1, 32'h1);
      @(posedge i_core_clk);
      `CHK(o_irq, 1'b0)
    end
    apb(8'h2c, 1'b1, 32'h0);
    apb(8'h08, 1'b1, 32'd40);
    rd(8'h10, 32'h1);
    apb(8'h0c, 1'b1, 32'h1);
    rd(8'h10, 32'h0);
    repeat (50) @(posedge i_core_clk);
    rd(8'h20, 32'h0);
    rd(8'h8c, 32'h0);
    report_and_stop();
  end
endmodule
